// *** logic/vpo_pkg.sv ***
// Constants shared by the video pixel output port
package vpo_pkg;
  // Register offsets
  localparam logic [7:0] VPO_A_TIMING_CTL = 8'h04;
  localparam logic [7:0] VPO_A_HB_BEG_LO  = 8'h30;
  localparam logic [7:0] VPO_A_HB_BEG_HI  = 8'h31;
  localparam logic [7:0] VPO_A_HB_FIN     = 8'h32;
  localparam logic [7:0] VPO_A_VB_BEG_LO  = 8'h33;
  localparam logic [7:0] VPO_A_VB_BEG_HI  = 8'h34;
  localparam logic [7:0] VPO_A_VB_FIN     = 8'h35;
  localparam logic [7:0] VPO_A_PORT_MODE  = 8'h40;
  localparam logic [7:0] VPO_A_HCNT_LO    = 8'h41;
  localparam logic [7:0] VPO_A_STATUS     = 8'h42;
  // Field positions in the timing control register
  localparam int VPO_B_LATCH_SEL = 4;
  localparam int VPO_B_DUTY_SEL  = 5;
  // Reset values
  localparam logic [7:0] VPO_R_TIMING_CTL = 8'h00;
  localparam logic [9:0] VPO_R_HB_BEG     = 10'h34a;
  localparam logic [7:0] VPO_R_HB_FIN     = 8'h7a;
  localparam logic [9:0] VPO_R_VB_BEG     = 10'h103;
  localparam logic [7:0] VPO_R_VB_FIN     = 8'h13;
  localparam logic [2:0] VPO_R_MODE       = 3'h0;
  // Output mode codes
  localparam logic [2:0] VPO_M_YC8   = 3'h0;
  localparam logic [2:0] VPO_M_YC16  = 3'h1;
  localparam logic [2:0] VPO_M_RGB15 = 3'h2;
  localparam logic [2:0] VPO_M_RGB16 = 3'h3;
  localparam logic [2:0] VPO_M_B656  = 3'h4;
  // Blanking levels and timing reference bytes
  localparam logic [7:0] VPO_LUMA_BLK   = 8'h10;
  localparam logic [7:0] VPO_CHROMA_BLK = 8'h80;
  localparam logic [7:0] VPO_TRS_ONES   = 8'hff;
  localparam logic [7:0] VPO_TRS_ZERO   = 8'h00;
  // Pixel counts ahead of blank end at which start-of-active begins
  localparam logic [9:0] VPO_SAV_LEAD   = 10'h002;
  // Timing reference sequencer states
  typedef enum logic [4:0] {
    VPO_T_IDLE = 5'b00001,
    VPO_T_ONES = 5'b00010,
    VPO_T_Z1   = 5'b00100,
    VPO_T_Z2   = 5'b01000,
    VPO_T_STAT = 5'b10000
  } vpo_trs_e;
endpackage : vpo_pkg

// *** logic/vpo_trs_word.sv ***
// Status byte of a timing reference code
`timescale 1ns/1ps
`default_nettype none
module vpo_trs_word (
  // Frame flags
  input  wire logic       fld,
  input  wire logic       vbl,
  input  wire logic       hfl,
  // Status byte
  output logic [7:0] word
);
  // Fixed one, flags, then protection bits
  assign word = {1'b1, fld, vbl, hfl,
                 vbl ^ hfl, fld ^ hfl, fld ^ vbl,
                 fld ^ vbl ^ hfl};
  // No clock here; the byte is checked where it reaches the pixel bus
endmodule : vpo_trs_word
`default_nettype wire

// *** logic/vpo_top.sv ***
// Video pixel output port: blanking timing and pixel bus formatting
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vpo_top
  import vpo_pkg::*;
#(
  parameter int CW = 10  // Pixel and line counter width
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  // Timing inputs from sync detection
  input  wire logic               sync_tip,
  input  wire logic               field_start,
  input  wire logic               field_in,
  input  wire logic               hsync_in_n,
  input  wire logic               vsync_in_n,
  // Decoded pixel stream
  input  wire logic               pix_tick,
  input  wire logic [7:0]         y_in,
  input  wire logic [7:0]         c_in,
  input  wire logic [15:0]        rgb_in,
  // Raw VBI and ancillary data
  input  wire logic               vbi_in,
  input  wire logic [7:0]         vbi_s0,
  input  wire logic [7:0]         vbi_s1,
  input  wire logic               anc_valid,
  input  wire logic [7:0]         anc_byte,
  // Pixel port outputs
  output logic [15:0]             pixel_bus,
  output logic                    blank_n,
  output logic                    hsync_n,
  output logic                    vsync_n,
  output logic                    pixel_qualify_strobe_n,
  output logic                    vbi_payload_flag_n,
  output logic                    field_out
);
  import vpo_pkg::*;

  // Programmed registers
  logic [7:0]    timing_ctl_reg;   // Strobe control
  logic [9:0]    hb_beg_reg;       // Horizontal blank start
  logic [7:0]    hb_fin_reg;       // Horizontal blank end
  logic [9:0]    vb_beg_reg;       // Vertical blank start line
  logic [7:0]    vb_fin_reg;       // Vertical blank end line
  logic [2:0]    mode_reg;         // Output format
  // Timing state
  // Counters are CW wide; the blank start registers keep ten bits, the end registers eight
  logic [CW-1:0] hcnt_reg;         // Pixel counter
  logic [CW-1:0] line_reg;         // Line counter in field
  logic          hblank_reg;       // Horizontal blank
  logic [1:0]    phase_reg;        // 8-bit byte phase
  logic          strobe_tgl_reg;   // Free half-rate strobe
  vpo_trs_e      trs_reg;          // Reference sequencer
  vpo_trs_e      trs_next;
  logic          trs_h_reg;        // H flag of current code

  // Register decode
  wire w_tctl  = reg_wr && (reg_addr == VPO_A_TIMING_CTL);
  wire w_hblo  = reg_wr && (reg_addr == VPO_A_HB_BEG_LO);
  wire w_hbhi  = reg_wr && (reg_addr == VPO_A_HB_BEG_HI);
  wire w_hbfin = reg_wr && (reg_addr == VPO_A_HB_FIN);
  wire w_vblo  = reg_wr && (reg_addr == VPO_A_VB_BEG_LO);
  wire w_vbhi  = reg_wr && (reg_addr == VPO_A_VB_BEG_HI);
  wire w_vbfin = reg_wr && (reg_addr == VPO_A_VB_FIN);
  wire w_mode  = reg_wr && (reg_addr == VPO_A_PORT_MODE);

  // Mode decode
  wire m_yc8   = (mode_reg == VPO_M_YC8);
  wire m_yc16  = (mode_reg == VPO_M_YC16);
  wire m_rgb15 = (mode_reg == VPO_M_RGB15);
  wire m_rgb16 = (mode_reg == VPO_M_RGB16);
  wire m_656   = (mode_reg == VPO_M_B656);
  wire m_wide  = m_yc16 | m_rgb15 | m_rgb16;
  wire latch_sel = timing_ctl_reg[VPO_B_LATCH_SEL];
  wire duty_sel  = timing_ctl_reg[VPO_B_DUTY_SEL];

  // Horizontal compare ignores bit 0: two-pixel steps
  // An odd programmed position acts as the even one below it
  wire hb_set = pix_tick && (hcnt_reg[CW-1:1] == hb_beg_reg[9:1]);
  wire [9:0] hb_fin_w = {2'b00, hb_fin_reg};
  wire hb_clr = pix_tick && (hcnt_reg[CW-1:1] == hb_fin_w[9:1]);
  // Start-of-active code leads blank end by two pixels
  wire [9:0] sav_at = hb_fin_w - VPO_SAV_LEAD;
  wire sav_hit = pix_tick && hblank_reg && (hcnt_reg == sav_at);
  // Whole lines blanked between start and end lines
  // A start line at or below the end line blanks the whole field
  wire vblank = (line_reg >= vb_beg_reg) || (line_reg < {2'b00, vb_fin_reg});
  wire blank_int = hblank_reg | vblank;
  wire trs_busy  = (trs_reg != VPO_T_IDLE);
  // A match while a reference is still going out is dropped
  wire trs_go    = m_656 && !trs_busy && ((hb_set && !hblank_reg) || sav_hit);
  wire vbi_on    = vbi_in && blank_int;
  // Flag follows the blank output, which a reference holds low as well
  wire vbi_flag  = vbi_in && (blank_int || trs_busy);

  // Status byte for the code now being sent
  logic [7:0] status_byte;
  vpo_trs_word u_word (
    .fld  (field_in),
    .vbl  (vblank),
    .hfl  (trs_h_reg),
    .word (status_byte)
  );

  // Register writes
  // High bytes keep two bits; upper write bits are dropped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timing_ctl_reg <= VPO_R_TIMING_CTL;
      hb_beg_reg     <= VPO_R_HB_BEG;
      hb_fin_reg     <= VPO_R_HB_FIN;
      vb_beg_reg     <= VPO_R_VB_BEG;
      vb_fin_reg     <= VPO_R_VB_FIN;
      mode_reg       <= VPO_R_MODE;
    end else begin
      if (w_tctl)  timing_ctl_reg   <= reg_wdata;
      if (w_hblo)  hb_beg_reg[7:0]  <= reg_wdata;
      if (w_hbhi)  hb_beg_reg[9:8]  <= reg_wdata[1:0];
      if (w_hbfin) hb_fin_reg       <= reg_wdata;
      if (w_vblo)  vb_beg_reg[7:0]  <= reg_wdata;
      if (w_vbhi)  vb_beg_reg[9:8]  <= reg_wdata[1:0];
      if (w_vbfin) vb_fin_reg       <= reg_wdata;
      if (w_mode)  mode_reg         <= reg_wdata[2:0];
    end
  end

  // Read data mux; unmapped addresses read zero
  // Count and status reads show live values, not a snapshot
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      VPO_A_TIMING_CTL: rd_mux = timing_ctl_reg;
      VPO_A_HB_BEG_LO:  rd_mux = hb_beg_reg[7:0];
      VPO_A_HB_BEG_HI:  rd_mux = {6'h00, hb_beg_reg[9:8]};
      VPO_A_HB_FIN:     rd_mux = hb_fin_reg;
      VPO_A_VB_BEG_LO:  rd_mux = vb_beg_reg[7:0];
      VPO_A_VB_BEG_HI:  rd_mux = {6'h00, vb_beg_reg[9:8]};
      VPO_A_VB_FIN:     rd_mux = vb_fin_reg;
      VPO_A_PORT_MODE:  rd_mux = {5'h00, mode_reg};
      VPO_A_HCNT_LO:    rd_mux = hcnt_reg[7:0];
      VPO_A_STATUS:     rd_mux = {3'h0, field_in, vblank, hblank_reg, hcnt_reg[9:8]};
      default:          rd_mux = 8'h00;
    endcase
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) reg_rdata <= 8'h00;
    else       reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  // Pixel and line counters
  // Counters wrap silently; longer lines than CW allows are not supported
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hcnt_reg <= '0;
      line_reg <= '0;
    end else begin
      if (sync_tip)      hcnt_reg <= '0;
      else if (pix_tick) hcnt_reg <= hcnt_reg + 1'b1;
      if (field_start)   line_reg <= CW'(1);
      else if (sync_tip) line_reg <= line_reg + 1'b1;
    end
  end

  // Horizontal blank flag; set wins when both match
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)       hblank_reg <= 1'b1;
    else if (hb_set) hblank_reg <= 1'b1;
    else if (hb_clr) hblank_reg <= 1'b0;
  end

  // Byte phase restarts with active video so Cb leads
  // Which chroma is sent comes from the source, not from this phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)           phase_reg <= 2'h0;
    else if (blank_int)  phase_reg <= 2'h0;
    else                 phase_reg <= phase_reg + 2'h1;
  end

  // Timing reference sequencer
  // One-hot states; an illegal code falls back to idle
  always_comb begin
    unique case (trs_reg)
      VPO_T_IDLE: trs_next = trs_go ? VPO_T_ONES : VPO_T_IDLE;
      VPO_T_ONES: trs_next = VPO_T_Z1;
      VPO_T_Z1:   trs_next = VPO_T_Z2;
      VPO_T_Z2:   trs_next = VPO_T_STAT;
      VPO_T_STAT: trs_next = VPO_T_IDLE;
      default:    trs_next = VPO_T_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trs_reg   <= VPO_T_IDLE;
      trs_h_reg <= 1'b0;
    end else begin
      trs_reg <= trs_next;
      if (trs_go) trs_h_reg <= !sav_hit;
    end
  end

  // Free-running half-rate strobe for the regular strobe form
  // Runs whatever the mode, so its phase against pixels is arbitrary
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) strobe_tgl_reg <= 1'b0;
    else       strobe_tgl_reg <= !strobe_tgl_reg;
  end

  // Pixel bus next value per mode
  logic [15:0] bus_next;
  logic [7:0]  byte8;
  always_comb begin
    byte8    = (phase_reg[0]) ? y_in : c_in;
    bus_next = 16'h0000;
    // Raw VBI outranks blanking levels but never a reference code
    if (vbi_on && !(m_656 && trs_busy)) begin
      bus_next = m_wide ? {vbi_s0, vbi_s1} : {vbi_s0, 8'h00};
    end else if (m_656) begin
      unique case (trs_reg)
        VPO_T_ONES: bus_next = {VPO_TRS_ONES, 8'h00};
        VPO_T_Z1,
        VPO_T_Z2:   bus_next = {VPO_TRS_ZERO, 8'h00};
        VPO_T_STAT: bus_next = {status_byte, 8'h00};
        default: begin
          if (!blank_int)     bus_next = {byte8, 8'h00};
          else if (anc_valid) bus_next = {anc_byte, 8'h00};
          else bus_next = {phase_reg[0] ? VPO_LUMA_BLK : VPO_CHROMA_BLK, 8'h00};
        end
      endcase
    end else if (m_yc8) begin
      if (blank_int) bus_next = {phase_reg[0] ? VPO_LUMA_BLK : VPO_CHROMA_BLK, 8'h00};
      else           bus_next = {byte8, 8'h00};
    end else if (m_yc16) begin
      bus_next = blank_int ? {VPO_LUMA_BLK, VPO_CHROMA_BLK} : {y_in, c_in};
    end else if (m_rgb15) begin
      bus_next = blank_int ? 16'h0000 : {1'b0, rgb_in[14:0]};
    end else if (m_rgb16) begin
      bus_next = blank_int ? 16'h0000 : rgb_in;
    end
  end

  // Strobe, asserted high internally
  // Latch form overrides the duty choice; software must use it active low
  logic strobe_next;
  always_comb begin
    if (trs_busy)       strobe_next = 1'b0;
    else if (latch_sel) strobe_next = 1'b1;
    else if (m_wide)    strobe_next = duty_sel ? pix_tick : strobe_tgl_reg;
    else                strobe_next = 1'b1;
  end

  // All port outputs leave together after the clock edge
  // Syncs pass one flop only, so they trail their source by a cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pixel_bus              <= 16'h0000;
      blank_n                <= 1'b0;
      hsync_n                <= 1'b1;
      vsync_n                <= 1'b1;
      pixel_qualify_strobe_n <= 1'b1;
      vbi_payload_flag_n     <= 1'b1;
      field_out              <= 1'b0;
    end else begin
      pixel_bus              <= bus_next;
      blank_n                <= !(blank_int || trs_busy);
      hsync_n                <= hsync_in_n;
      vsync_n                <= vsync_in_n;
      pixel_qualify_strobe_n <= !strobe_next;
      vbi_payload_flag_n     <= !vbi_flag;
      field_out              <= field_in;
    end
  end

  // Checks on the logic above
  // Mode writes are excluded where the next cycle changes form
  a_count_zero : assert property (@(posedge clock) disable iff (!rstn)
    sync_tip |=> (hcnt_reg == '0)) else $error("counter not zero after sync tip");
  a_hblank_set : assert property (@(posedge clock) disable iff (!rstn)
    hb_set |=> hblank_reg) else $error("blank did not start");
  a_hblank_clear : assert property (@(posedge clock) disable iff (!rstn)
    (hb_clr && !hb_set) |=> !hblank_reg) else $error("blank did not end");
  a_vblank_whole : assert property (@(posedge clock) disable iff (!rstn)
    (vblank && !trs_busy && $stable(line_reg)) |=> !blank_n) else $error("blanked line shows active");
  a_rgb15_top : assert property (@(posedge clock) disable iff (!rstn)
    (m_rgb15 && !vbi_on && !w_mode) |=> (pixel_bus[15] == 1'b0)) else $error("rgb15 top bit set");
  a_blank_level : assert property (@(posedge clock) disable iff (!rstn)
    (m_yc16 && blank_int && !vbi_in && !w_mode) |=> (pixel_bus == 16'h1080)) else $error("blank level wrong");
  a_trs_sequence : assert property (@(posedge clock) disable iff (!rstn)
    (trs_go && !vbi_in) |=> ##1 (pixel_bus[15:8] == 8'hff) ##1 (pixel_bus[15:8] == 8'h00)
      ##1 (pixel_bus[15:8] == 8'h00)) else $error("reference sequence wrong");
  a_trs_no_strobe : assert property (@(posedge clock) disable iff (!rstn)
    trs_busy |=> (pixel_qualify_strobe_n && !blank_n)) else $error("strobe during reference");
  a_latch_strobe : assert property (@(posedge clock) disable iff (!rstn)
    (latch_sel && !trs_busy && !w_tctl) |=> !pixel_qualify_strobe_n) else $error("latch strobe not held");
  a_raw_vbi_lanes : assert property (@(posedge clock) disable iff (!rstn)
    (vbi_on && m_wide && !w_mode) |=> (pixel_bus == {$past(vbi_s0), $past(vbi_s1)})) else $error("vbi lanes");
  a_prot_bits : assert property (@(posedge clock) disable iff (!rstn)
    (m_656 && (trs_reg == VPO_T_STAT) && !w_mode) |=> (pixel_bus[15] && (pixel_bus[11:8] == {
      pixel_bus[13] ^ pixel_bus[12], pixel_bus[14] ^ pixel_bus[12], pixel_bus[14] ^ pixel_bus[13],
      pixel_bus[14] ^ pixel_bus[13] ^ pixel_bus[12]}))) else $error("protection bits wrong");
  a_narrow_low_lane : assert property (@(posedge clock) disable iff (!rstn)
    ((m_yc8 || m_656) && !w_mode) |=> (pixel_bus[7:0] == 8'h00)) else $error("low lane not zero");
  a_rgb_blank : assert property (@(posedge clock) disable iff (!rstn)
    ((m_rgb15 || m_rgb16) && blank_int && !vbi_in && !w_mode) |=> (pixel_bus == 16'h0000))
    else $error("rgb blank not zero");
  a_duty_strobe : assert property (@(posedge clock) disable iff (!rstn)
    (m_wide && duty_sel && !latch_sel && !trs_busy) |=> (pixel_qualify_strobe_n == !$past(pix_tick)))
    else $error("duty strobe wrong");
  a_sav_h_low : assert property (@(posedge clock) disable iff (!rstn)
    (trs_go && sav_hit) |=> !trs_h_reg) else $error("start code marked as end");
endmodule : vpo_top
`default_nettype wire

// *** tb/vpo_cap.sv ***
// Capture-side model of the pixel port receiver
`timescale 1ns/1ps
`default_nettype none
module vpo_cap (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Pixel port
  input  wire logic [15:0] pixel_bus,
  input  wire logic        strobe_n,
  // Pixels taken so far
  output int               n_taken
);
  // Takes a pixel only when the strobe qualifies it; the rate may jitter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      n_taken <= 0;
    end else if (!strobe_n) begin  // Qualified pixel
      n_taken <= n_taken + 1;
    end
  end
endmodule : vpo_cap
`default_nettype wire

// *** tb/vpo_top_tb_top.sv ***
// Self-checking bench for the video pixel output port
`timescale 1ns/1ps
`default_nettype none
module vpo_top_tb_top;
  import vpo_pkg::*;
  logic        clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, sync_tip = 0, field_start = 0, field_in = 0;
  logic        hsync_in_n = 1, vsync_in_n = 1, pix_tick = 0, vbi_in = 0, anc_valid = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, y_in = 0, c_in = 0, vbi_s0 = 0, vbi_s1 = 0, anc_byte = 0, reg_rdata;
  logic [15:0] rgb_in = 0, pixel_bus, p_rgb;
  logic        blank_n, hsync_n, vsync_n, pixel_qualify_strobe_n, vbi_payload_flag_n, field_out;
  logic [7:0]  p_y, p_c, p_s0, p_s1;       // Inputs seen at the last edge
  logic        p_tick, p_vbi, p_anc, p_hs, p_vs, p_fld, p_stb;
  logic [2:0]  mode;                       // Port mode in force
  logic [7:0]  ctl;                        // Timing control in force
  logic        mon_on = 0, vexp = 0, fld_l = 0;
  int          seed = 58666, num_errors = 0, compares = 0, rs = 0, nref = 0, nact = 0, ph = 0, nq;
  logic [7:0]  regs [7] = '{VPO_A_TIMING_CTL, VPO_A_HB_BEG_LO, VPO_A_HB_BEG_HI, VPO_A_HB_FIN,
                            VPO_A_VB_BEG_LO, VPO_A_VB_BEG_HI, VPO_A_VB_FIN};

  vpo_top #(.CW(10)) uut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_tip(sync_tip), .field_start(field_start),
    .field_in(field_in), .hsync_in_n(hsync_in_n), .vsync_in_n(vsync_in_n), .pix_tick(pix_tick), .y_in(y_in),
    .c_in(c_in), .rgb_in(rgb_in), .vbi_in(vbi_in), .vbi_s0(vbi_s0), .vbi_s1(vbi_s1), .anc_valid(anc_valid),
    .anc_byte(anc_byte), .pixel_bus(pixel_bus), .blank_n(blank_n), .hsync_n(hsync_n), .vsync_n(vsync_n),
    .pixel_qualify_strobe_n(pixel_qualify_strobe_n), .vbi_payload_flag_n(vbi_payload_flag_n),
    .field_out(field_out));
  vpo_cap cap (.clock(clock), .rstn(rstn), .pixel_bus(pixel_bus), .strobe_n(pixel_qualify_strobe_n),
    .n_taken(nq));

  // Free-running 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  // Random pixel stream; bytes keep bit 0 low so none can mimic a reference
  always @(posedge clock) begin
    y_in       <= 8'($random(seed)) & 8'h7e;
    c_in       <= 8'($random(seed)) & 8'hfe | 8'h80;
    rgb_in     <= 16'($random(seed));
    vbi_s0     <= 8'($random(seed)) & 8'hfe;
    vbi_s1     <= 8'($random(seed)) & 8'hfe;
    anc_byte   <= 8'($random(seed)) & 8'hfe;
    anc_valid  <= 1'($random(seed));
    hsync_in_n <= 1'($random(seed));
    vsync_in_n <= 1'($random(seed));
  end

  // Snapshot of what the design samples at each edge
  always @(posedge clock) begin
    {p_y, p_c, p_s0, p_s1, p_rgb, p_tick, p_vbi, p_anc, p_hs, p_vs, p_fld} <=
      {y_in, c_in, vbi_s0, vbi_s1, rgb_in, pix_tick, vbi_in, anc_valid, hsync_in_n, vsync_in_n, field_in};
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] sts(input logic f, input logic v, input logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction : sts

  // Cycle checker, half a cycle after each launch
  always @(negedge clock) begin : mon
    logic [7:0]  hb;
    logic [15:0] exp;
    logic        blk, wide, duty, refb;
    hb   = pixel_bus[15:8];
    blk  = !blank_n;
    wide = mode inside {VPO_M_YC16, VPO_M_RGB15, VPO_M_RGB16};
    duty = ctl[VPO_B_DUTY_SEL] && !ctl[VPO_B_LATCH_SEL];
    refb = (mode == VPO_M_B656) && (rs != 0 || hb == VPO_TRS_ONES);
    if (mon_on) begin
      chk("sync_field", 16'({p_hs, p_vs, p_fld}), 16'({hsync_n, vsync_n, field_out}));
      chk("vbi_flag_n", 16'(!(p_vbi && blk)), 16'(vbi_payload_flag_n));
      if (refb) begin
        chk("ref_strobe_blank", 16'h0002, 16'({pixel_qualify_strobe_n, blank_n}));
        if (rs == 3) chk("ref_status", {sts(fld_l, vexp, nref == 1), 8'h00}, pixel_bus);
        else if (rs != 0) chk("ref_zero", 16'h0000, pixel_bus);
        nref = nref + int'(rs == 3);
        rs   = (rs + 1) % 4;
      end else begin
        // Strobe form per mode and control bits
        if (wide && ctl[VPO_B_DUTY_SEL:VPO_B_LATCH_SEL] == 2'b00)
          chk("strobe_toggle", 16'(!p_stb), 16'(pixel_qualify_strobe_n));
        else if (wide && duty) chk("strobe_tick", 16'(!p_tick), 16'(pixel_qualify_strobe_n));
        else chk("strobe_on", 16'h0000, 16'(pixel_qualify_strobe_n));
        if (!blk) begin
          nact++;
          case (mode)
            VPO_M_YC16:  exp = {p_y, p_c};
            VPO_M_RGB15: exp = {1'b0, p_rgb[14:0]};
            VPO_M_RGB16: exp = p_rgb;
            default:     exp = {ph[0] ? p_y : p_c, 8'h00};
          endcase
          chk("active_data", exp, pixel_bus);
          ph++;
        end else begin
          ph = 0;
          if (p_vbi && mode != VPO_M_B656) chk("raw_vbi", wide ? {p_s0, p_s1} : {p_s0, 8'h00}, pixel_bus);
          else if (!p_vbi && !(mode == VPO_M_B656 && p_anc)) begin
            if (mode inside {VPO_M_RGB15, VPO_M_RGB16}) chk("blank_rgb", 16'h0000, pixel_bus);
            else if (mode == VPO_M_YC16) chk("blank_yc", {VPO_LUMA_BLK, VPO_CHROMA_BLK}, pixel_bus);
            else chk("blank_byte", 16'h0001, 16'(pixel_bus[7:0] == 8'h00 &&
                     hb inside {VPO_LUMA_BLK, VPO_CHROMA_BLK}));
          end
        end
      end
    end
    p_stb = pixel_qualify_strobe_n;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", 16'(e), 16'(reg_rdata));
  endtask : rd

  // Mode change with checking paused while it settles
  task automatic cfg(input logic [2:0] m, input logic [7:0] c);
    mon_on = 0;
    wr(VPO_A_PORT_MODE, {5'h00, m});
    wr(VPO_A_TIMING_CTL, c);
    mode = m;
    ctl  = c;
    repeat (2) @(posedge clock);
    mon_on = 1;
  endtask : cfg

  // One line: sync tip, field start, 28 pixels at one every two clocks
  task automatic run_line();
    int q0;
    q0   = nq;
    rs   = 0;
    nref = 0;
    nact = 0;
    @(posedge clock);
    sync_tip <= 1'b1;
    @(posedge clock);
    sync_tip    <= 1'b0;
    field_start <= 1'b1;
    @(posedge clock);
    field_start <= 1'b0;
    for (int i = 0; i < 28; i++) begin
      pix_tick <= 1'b1;
      @(posedge clock);
      pix_tick <= 1'b0;
      @(posedge clock);
    end
    repeat (2) @(posedge clock);
    rd(VPO_A_HCNT_LO, 8'd28);
    rd(VPO_A_STATUS, {3'b000, fld_l, vexp, 1'b1, 2'b00});
    // Active from pixel 4 to pixel 20 after two-pixel rounding of 5 and 21
    if (mode != VPO_M_B656) chk("active_len", vexp ? 16'd0 : 16'd32, 16'(nact));
    else chk("ref_count", 16'd2, 16'(nref));
    if (ctl == 8'h20 && mode inside {VPO_M_YC16, VPO_M_RGB15, VPO_M_RGB16})
      chk("taken", 16'd28, 16'(nq - q0));
  endtask : run_line

  task automatic close_out();
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    close_out();
  end

  initial begin : main
    logic [7:0] r;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    rd(VPO_A_TIMING_CTL, VPO_R_TIMING_CTL);
    rd(VPO_A_HB_BEG_HI, {6'h00, VPO_R_HB_BEG[9:8]});
    rd(VPO_A_HB_FIN, VPO_R_HB_FIN);
    rd(VPO_A_VB_BEG_LO, VPO_R_VB_BEG[7:0]);
    rd(VPO_A_VB_FIN, VPO_R_VB_FIN);
    wr(8'h77, 8'h5a);
    rd(8'h77, 8'h00);
    // Write and read back every timing register; high bytes keep two bits
    foreach (regs[i]) begin
      r = 8'($random(seed));
      wr(regs[i], r);
      rd(regs[i], (regs[i] inside {VPO_A_HB_BEG_HI, VPO_A_VB_BEG_HI}) ? (r & 8'h03) : r);
    end
    wr(VPO_A_HB_BEG_LO, 8'h15);
    wr(VPO_A_HB_BEG_HI, 8'h00);
    wr(VPO_A_HB_FIN, 8'h05);
    wr(VPO_A_VB_BEG_LO, 8'h03);
    wr(VPO_A_VB_BEG_HI, 8'h01);
    // Every mode with each strobe setting, active and blanked lines, both fields
    for (int m = 0; m < 5; m++) begin
      for (int k = 0; k < 3; k++) begin
        cfg(3'(m), (k == 0) ? 8'h00 : ((k == 1) ? 8'h10 : 8'h20));
        for (int v = 1; v < 3; v++) begin
          for (int f = 0; f < 2; f++) begin
            wr(VPO_A_VB_FIN, 8'(v));
            vexp     = (v == 2);
            fld_l    = 1'(f);
            field_in <= 1'(f);
            vbi_in   <= 1'($random(seed));
            run_line();
          end
        end
      end
    end
    close_out();
  end
endmodule : vpo_top_tb_top
`default_nettype wire
